// [verilog/hpp_pkg.sv]
/*
 * hpp_pkg: shared types and constants of the host parallel port,
 * used by the device end, the host end and the pin interface.
 * assumes: both ends run on the same 250 MHz system clock.
 */
`default_nettype none

package hpp_pkg;

	// ------------------------------------------------------------
	// widths and types
	// ------------------------------------------------------------
	localparam int unsigned HPP_DATA_W = 8;
	localparam int unsigned HPP_ADDR_W = 4;

	typedef logic [HPP_DATA_W-1:0] hpp_data_t;
	typedef logic [HPP_ADDR_W-1:0] hpp_addr_t;

	typedef enum logic {
		HPP_MODE_DIRECT,
		HPP_MODE_MUX
	} hpp_mode_t;

	typedef enum logic [2:0] {
		HPP_H_IDLE,
		HPP_H_ADDR,
		HPP_H_HOLD,
		HPP_H_STROBE,
		HPP_H_RECOVER
	} hpp_hst_t;

	// pin sample as seen by the device end
	typedef struct packed {
		logic      ale;
		logic      cs_n;
		logic      rd_n;
		logic      wr_n;
		logic      aux;
		hpp_addr_t sel;
		hpp_data_t bus;
	} hpp_pins_t;

	// ------------------------------------------------------------
	// reset values and timing counts
	// ------------------------------------------------------------
	localparam hpp_pins_t HPP_PINS_RST = '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
		wr_n: 1'b1, aux: 1'b0, sel: 4'h0, bus: 8'h00};
	localparam hpp_data_t HPP_DATA_RST   = 8'h00;
	localparam hpp_addr_t HPP_ADDR_RST   = 4'h0;
	localparam hpp_data_t HPP_BUS_PULL   = 8'hFF;
	localparam logic [1:0] HPP_SETTLE_CYC = 2'h3;
	localparam logic [1:0] HPP_SETTLE_RST = 2'h0;
	localparam logic [1:0] HPP_SETTLE_INC = 2'h1;
	localparam int unsigned HPP_PHASE_CYC  = 4;
	localparam int unsigned HPP_STROBE_CYC = 12;
	localparam int unsigned HPP_CNT_W      = 8;
	localparam logic [HPP_CNT_W-1:0] HPP_CNT_ZERO = 8'h00;
	localparam logic [HPP_CNT_W-1:0] HPP_CNT_ONE  = 8'h01;

endpackage : hpp_pkg

`default_nettype wire

// [verilog/hpp_port_if.sv]
/*
 * hpp_port_if: the pins between host and device end.
 * assumes: the shared data bus is resolved here from the two enables;
 * an undriven bus reads as the pull-up level.
 */
`timescale 1ns/10ps
`default_nettype none

interface hpp_port_if;
	import hpp_pkg::*;

	logic      ale;
	logic      cs_n;
	logic      rd_n;
	logic      wr_n;
	hpp_addr_t register_select_lines;
	hpp_data_t host_data;
	logic      host_oe;
	hpp_data_t dev_data;
	logic      dev_oe;
	hpp_data_t host_bus_lines;
	logic      int_n;

	// device wins a clash so its read data is never masked
	assign host_bus_lines = dev_oe ? dev_data : (host_oe ? host_data : HPP_BUS_PULL);

	modport dev (
		input  ale,
		input  cs_n,
		input  rd_n,
		input  wr_n,
		input  register_select_lines,
		input  host_bus_lines,
		output dev_data,
		output dev_oe,
		output int_n
	);

	modport host (
		output ale,
		output cs_n,
		output rd_n,
		output wr_n,
		output register_select_lines,
		output host_data,
		output host_oe,
		input  host_bus_lines,
		input  int_n
	);

endinterface : hpp_port_if

`default_nettype wire

// [verilog/hpp_dev_end.sv]
/*
 * hpp_dev_end: device end of the host parallel port. detects bus
 * style, decodes strobes, issues register reads and writes, drives
 * read data and the interrupt pin.
 * assumes: register file answers reg_rdata_in in the cycle reg_rd_out
 * is high; all pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - bus carries data, or address then data
// - direct mode after reset until ALE rises
// - ALE rising edge selects multiplexed mode
// - reset or chip select release ends multiplexed
// - direct-bus host holds ALE constant
// - ALE falling edge latches address bits 3-0
// - address latched regardless of chip select
// - multiplexed strobes act only with chip select
// - direct mode addresses from select lines
// - direct mode read strobe picks direction
// - direct access while write and select low
// - multiplexed host ties select lines fixed
// - no access without chip select low
// - interrupt low while enabled source pending
// - auxiliary interrupt pin is extra source
module hpp_dev_end #(
	parameter int unsigned IRQ_N = 4
) (
	// clock, reset, enable
	input  wire logic               clk_sys_in,
	input  wire logic               nrst_in,
	input  wire logic               ce_in,
	// host pins
	hpp_port_if.dev                 port,
	// auxiliary interrupt pin
	input  wire logic               aux_interrupt_in,
	// register side
	output logic                    reg_rd_out,
	output logic                    reg_wr_out,
	output hpp_pkg::hpp_addr_t      reg_addr_out,
	output hpp_pkg::hpp_data_t      reg_wdata_out,
	input  wire hpp_pkg::hpp_data_t reg_rdata_in,
	// interrupt sources and status
	input  wire logic [IRQ_N-1:0]   irq_src_in,
	input  wire logic [IRQ_N-1:0]   irq_en_in,
	input  wire logic               aux_irq_en_in,
	output logic                    aux_irq_out,
	output logic                    mux_mode_out
);
	import hpp_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	hpp_pins_t pins_raw;
	hpp_pins_t sync1_q;
	hpp_pins_t sync2_q;
	hpp_pins_t sync1_d;
	hpp_pins_t sync2_d;

	always_comb begin
		pins_raw.ale  = port.ale;
		pins_raw.cs_n = port.cs_n;
		pins_raw.rd_n = port.rd_n;
		pins_raw.wr_n = port.wr_n;
		pins_raw.aux  = aux_interrupt_in;
		pins_raw.sel  = port.register_select_lines;
		pins_raw.bus  = port.host_bus_lines;
		sync1_d = pins_raw;
		sync2_d = sync1_q;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_q <= HPP_PINS_RST;
			sync2_q <= HPP_PINS_RST;
		end else if (ce_in) begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
		end
	end

	// ------------------------------------------------------------
	// mode, decode and register strobes
	// ------------------------------------------------------------
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	hpp_mode_t  mode_q;
	hpp_mode_t  mode_d;
	logic       ale_p_q;
	logic       csn_p_q;
	hpp_addr_t  laddr_q;
	hpp_addr_t  laddr_d;
	logic       rd_act_q;
	logic       wr_act_q;
	logic       rd_act;
	logic       wr_act;
	logic       settled;
	logic       ale_rise;
	logic       ale_fall;
	logic       cs_rise;
	hpp_addr_t  addr_cur;
	logic       reg_rd_q;
	logic       reg_rd_d;
	logic       reg_wr_q;
	logic       reg_wr_d;
	hpp_addr_t  reg_addr_q;
	hpp_addr_t  reg_addr_d;
	hpp_data_t  reg_wdata_q;
	hpp_data_t  reg_wdata_d;
	hpp_data_t  dout_q;
	hpp_data_t  dout_d;
	logic       oe_q;
	logic       oe_d;
	logic       int_n_q;
	logic       int_n_d;
	logic       pend;

	always_comb begin
		// edges are ignored until the synchronisers hold real pin levels,
		// so an ALE strapped high cannot fake a rising edge at reset
		settled  = (settle_q == HPP_SETTLE_CYC);
		settle_d = settled ? settle_q : settle_q + HPP_SETTLE_INC;
		ale_rise = settled && sync2_q.ale && !ale_p_q;
		ale_fall = settled && !sync2_q.ale && ale_p_q;
		cs_rise  = settled && sync2_q.cs_n && !csn_p_q;

		mode_d = mode_q;
		if (ale_rise) begin
			mode_d = HPP_MODE_MUX;
		end else if (cs_rise) begin
			mode_d = HPP_MODE_DIRECT;
		end

		// any ALE fall latches, even with chip select high
		laddr_d = ale_fall ? sync2_q.bus[HPP_ADDR_W-1:0] : laddr_q;

		if (mode_q == HPP_MODE_MUX) begin
			addr_cur = laddr_q;
			rd_act   = !sync2_q.cs_n && !sync2_q.rd_n;
			wr_act   = !sync2_q.cs_n && !sync2_q.wr_n && sync2_q.rd_n;
		end else begin
			addr_cur = sync2_q.sel;
			rd_act   = !sync2_q.cs_n && !sync2_q.wr_n && sync2_q.rd_n;
			wr_act   = !sync2_q.cs_n && !sync2_q.wr_n && !sync2_q.rd_n;
		end
		rd_act = rd_act && settled;
		wr_act = wr_act && settled;

		// read issued at start; write issued at end with the last data seen
		reg_rd_d    = rd_act && !rd_act_q;
		reg_wr_d    = wr_act_q && !wr_act;
		reg_addr_d  = (rd_act || wr_act) ? addr_cur : reg_addr_q;
		reg_wdata_d = wr_act ? sync2_q.bus : reg_wdata_q;

		dout_d = reg_rd_q ? reg_rdata_in : dout_q;
		// enable rises with fresh data, never with stale data
		oe_d = rd_act && (reg_rd_q || oe_q);

		pend    = (|(irq_src_in & irq_en_in)) || (sync2_q.aux && aux_irq_en_in);
		int_n_d = !pend;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			settle_q    <= HPP_SETTLE_RST;
			mode_q      <= HPP_MODE_DIRECT;
			ale_p_q     <= HPP_PINS_RST.ale;
			csn_p_q     <= HPP_PINS_RST.cs_n;
			laddr_q     <= HPP_ADDR_RST;
			rd_act_q    <= 1'b0;
			wr_act_q    <= 1'b0;
			reg_rd_q    <= 1'b0;
			reg_wr_q    <= 1'b0;
			reg_addr_q  <= HPP_ADDR_RST;
			reg_wdata_q <= HPP_DATA_RST;
			dout_q      <= HPP_DATA_RST;
			oe_q        <= 1'b0;
			int_n_q     <= 1'b1;
		end else if (ce_in) begin
			settle_q    <= settle_d;
			mode_q      <= mode_d;
			ale_p_q     <= sync2_q.ale;
			csn_p_q     <= sync2_q.cs_n;
			laddr_q     <= laddr_d;
			rd_act_q    <= rd_act;
			wr_act_q    <= wr_act;
			reg_rd_q    <= reg_rd_d;
			reg_wr_q    <= reg_wr_d;
			reg_addr_q  <= reg_addr_d;
			reg_wdata_q <= reg_wdata_d;
			dout_q      <= dout_d;
			oe_q        <= oe_d;
			int_n_q     <= int_n_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rd_out    = reg_rd_q;
	assign reg_wr_out    = reg_wr_q;
	assign reg_addr_out  = reg_addr_q;
	assign reg_wdata_out = reg_wdata_q;
	assign port.dev_data = dout_q;
	assign port.dev_oe   = oe_q;
	assign port.int_n    = int_n_q;
	assign aux_irq_out   = sync2_q.aux;
	assign mux_mode_out  = (mode_q == HPP_MODE_MUX);

endmodule : hpp_dev_end

`default_nettype wire

// [verilog/hpp_host_end.sv]
/*
 * hpp_host_end: host end of the parallel port. turns one command into
 * a multiplexed or direct bus cycle on the pins.
 * assumes: device end samples pins through two flip-flops, so every
 * phase lasts several clocks; one command at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module hpp_host_end #(
	parameter int unsigned PHASE_CYC  = hpp_pkg::HPP_PHASE_CYC,
	parameter int unsigned STROBE_CYC = hpp_pkg::HPP_STROBE_CYC
) (
	// clock, reset, enable
	input  wire logic               clk_sys_in,
	input  wire logic               nrst_in,
	input  wire logic               ce_in,
	// device pins
	hpp_port_if.host                port,
	// command
	input  wire logic               cmd_valid_in,
	output logic                    cmd_ready_out,
	input  wire logic               cmd_write_in,
	input  wire logic               cmd_mux_in,
	input  wire hpp_pkg::hpp_addr_t cmd_addr_in,
	input  wire hpp_pkg::hpp_data_t cmd_wdata_in,
	// response and interrupt
	output logic                    rsp_valid_out,
	output hpp_pkg::hpp_data_t      rsp_rdata_out,
	output logic                    irq_out
);
	import hpp_pkg::*;

	localparam logic [HPP_CNT_W-1:0] PH_LAST = HPP_CNT_W'(PHASE_CYC - 1);
	localparam logic [HPP_CNT_W-1:0] ST_LAST = HPP_CNT_W'(STROBE_CYC - 1);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	hpp_data_t bus1_q;
	hpp_data_t bus2_q;
	logic      int1_q;
	logic      int2_q;

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus1_q <= HPP_BUS_PULL;
			bus2_q <= HPP_BUS_PULL;
			int1_q <= 1'b1;
			int2_q <= 1'b1;
		end else if (ce_in) begin
			bus1_q <= port.host_bus_lines;
			bus2_q <= bus1_q;
			int1_q <= port.int_n;
			int2_q <= int1_q;
		end
	end

	// ------------------------------------------------------------
	// bus cycle sequencer
	// ------------------------------------------------------------
	hpp_hst_t              st_q, st_d;
	logic [HPP_CNT_W-1:0]  cnt_q, cnt_d;
	logic                  wr_q, wr_d;
	logic                  mux_q, mux_d;
	hpp_data_t             wdata_q, wdata_d;
	logic                  ale_q, ale_d;
	logic                  csn_q, csn_d;
	logic                  rdn_q, rdn_d;
	logic                  wrn_q, wrn_d;
	hpp_addr_t             sel_q, sel_d;
	hpp_data_t             hdata_q, hdata_d;
	logic                  hoe_q, hoe_d;
	logic                  rsp_q, rsp_d;
	hpp_data_t             rdata_q, rdata_d;
	logic                  done;

	always_comb begin
		st_d = st_q;
		cnt_d = (cnt_q == HPP_CNT_ZERO) ? cnt_q : cnt_q - HPP_CNT_ONE;
		wr_d = wr_q;
		mux_d = mux_q;
		wdata_d = wdata_q;
		ale_d = ale_q;
		csn_d = csn_q;
		rdn_d = rdn_q;
		wrn_d = wrn_q;
		sel_d = sel_q;
		hdata_d = hdata_q;
		hoe_d = hoe_q;
		rsp_d = 1'b0;
		rdata_d = rdata_q;
		done = (cnt_q == HPP_CNT_ZERO);
		case (st_q)
			HPP_H_IDLE: begin
				if (cmd_valid_in) begin
					wr_d = cmd_write_in;
					mux_d = cmd_mux_in;
					wdata_d = cmd_wdata_in;
					cnt_d = PH_LAST;
					st_d = HPP_H_ADDR;
					hoe_d = 1'b1;
					if (cmd_mux_in) begin
						// address on the data lines, select lines tied low
						ale_d = 1'b1;
						sel_d = HPP_ADDR_RST;
						hdata_d = {{(HPP_DATA_W-HPP_ADDR_W){1'b0}}, cmd_addr_in};
					end else begin
						sel_d = cmd_addr_in;
						rdn_d = !cmd_write_in;
						hdata_d = cmd_wdata_in;
						hoe_d = cmd_write_in;
					end
				end
			end
			HPP_H_ADDR: begin
				if (done) begin
					cnt_d = PH_LAST;
					if (mux_q) begin
						ale_d = 1'b0;
						st_d = HPP_H_HOLD;
					end else begin
						csn_d = 1'b0;
						wrn_d = 1'b0;
						cnt_d = ST_LAST;
						st_d = HPP_H_STROBE;
					end
				end
			end
			HPP_H_HOLD: begin
				if (done) begin
					csn_d = 1'b0;
					cnt_d = ST_LAST;
					st_d = HPP_H_STROBE;
					if (wr_q) begin
						hdata_d = wdata_q;
						wrn_d = 1'b0;
					end else begin
						hoe_d = 1'b0;
						rdn_d = 1'b0;
					end
				end
			end
			HPP_H_STROBE: begin
				if (done) begin
					rdata_d = bus2_q;
					wrn_d = 1'b1;
					// direct mode keeps direction steady until select drops
					if (mux_q) begin
						rdn_d = 1'b1;
					end
					cnt_d = PH_LAST;
					st_d = HPP_H_RECOVER;
				end
			end
			HPP_H_RECOVER: begin
				if (done) begin
					csn_d = 1'b1;
					rdn_d = 1'b1;
					hoe_d = 1'b0;
					rsp_d = 1'b1;
					st_d = HPP_H_IDLE;
				end
			end
			default: begin
				st_d = HPP_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= HPP_H_IDLE;
			cnt_q <= HPP_CNT_ZERO;
			wr_q <= 1'b0;
			mux_q <= 1'b0;
			wdata_q <= HPP_DATA_RST;
			ale_q <= 1'b0;
			csn_q <= 1'b1;
			rdn_q <= 1'b1;
			wrn_q <= 1'b1;
			sel_q <= HPP_ADDR_RST;
			hdata_q <= HPP_DATA_RST;
			hoe_q <= 1'b0;
			rsp_q <= 1'b0;
			rdata_q <= HPP_DATA_RST;
		end else if (ce_in) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			mux_q <= mux_d;
			wdata_q <= wdata_d;
			ale_q <= ale_d;
			csn_q <= csn_d;
			rdn_q <= rdn_d;
			wrn_q <= wrn_d;
			sel_q <= sel_d;
			hdata_q <= hdata_d;
			hoe_q <= hoe_d;
			rsp_q <= rsp_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign port.ale = ale_q;
	assign port.cs_n = csn_q;
	assign port.rd_n = rdn_q;
	assign port.wr_n = wrn_q;
	assign port.register_select_lines = sel_q;
	assign port.host_data = hdata_q;
	assign port.host_oe = hoe_q;
	assign cmd_ready_out = (st_q == HPP_H_IDLE);
	assign rsp_valid_out = rsp_q;
	assign rsp_rdata_out = rdata_q;
	assign irq_out = !int2_q;

endmodule : hpp_host_end

`default_nettype wire

// [dv/hpp_port_checker.sv]
/*
 * hpp_port_checker: timing relations on the pins between host and device end.
 * assumes: instantiated once in the bench beside the interface that joins both ends.
 */
`timescale 1ns/10ps
`default_nettype none

module hpp_port_checker (
	// clock and reset
	input wire logic               clk_sys_in,
	input wire logic               nrst_in,
	// host driven pins
	input wire logic               ale,
	input wire logic               cs_n,
	input wire logic               rd_n,
	input wire logic               wr_n,
	input wire hpp_pkg::hpp_addr_t register_select_lines,
	// device driven bus
	input wire hpp_pkg::hpp_data_t dev_data,
	input wire logic               dev_oe
);
	import hpp_pkg::*;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	// ------------------------------------------------------------
	// pin rules
	// ------------------------------------------------------------
	property p_sel_mux; ale |-> register_select_lines == 4'h0; endproperty
	a_sel_mux: assert property (p_sel_mux) else $error("select lines not tied during address phase");
	property p_ale_direct; !cs_n && !ale |=> !ale; endproperty
	a_ale_direct: assert property (p_ale_direct) else $error("latch enable moved inside an access");
	property p_wr_cs; !wr_n |-> !cs_n; endproperty
	a_wr_cs: assert property (p_wr_cs) else $error("write strobe low without chip select");
	property p_oe_rise; $rose(dev_oe) |-> !$past(cs_n, 3) && ($past(rd_n, 3) != $past(wr_n, 3)); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("bus driven without a selected read");
	property p_oe_cs; cs_n [*5] |-> !dev_oe; endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("bus driven while deselected");
	property p_oe_hold; $rose(dev_oe) |=> (dev_oe && $stable(dev_data)) [*6]; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("read data not held on the bus");
	property p_ale_no_oe; ale |-> !dev_oe; endproperty
	a_ale_no_oe: assert property (p_ale_no_oe) else $error("bus driven in address phase");
	property p_ale_len; $rose(ale) |-> ale [*3]; endproperty
	a_ale_len: assert property (p_ale_len) else $error("address phase too short to latch");

	c_read: cover property ($rose(dev_oe));
	c_addr: cover property ($fell(ale));
	c_write: cover property ($rose(wr_n) && !cs_n);

endmodule : hpp_port_checker

`default_nettype wire

// [dv/host_parallel_bus_port_test.sv]
/*
 * host_parallel_bus_port_test: host end and device end joined, plus a second
 * device end on hand driven pins for refused and latched cases.
 * assumes: package, interface and both ends compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module host_parallel_bus_port_test;
	import hpp_pkg::*;

	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic ce = 1'h1;
	logic cmd_valid, cmd_write, cmd_mux, aux_in, aux_en, saw_mux, pend;
	logic cmd_ready, rsp_valid, irq, reg_rd, reg_wr, aux_irq, mux_mode;
	logic reg_rd2, reg_wr2, mux_mode2;
	logic [3:0] irq_src, irq_en;
	logic [13:0] r;
	logic [9:0] q;
	hpp_addr_t cmd_addr, reg_addr, reg_addr2, addr2;
	hpp_data_t cmd_wdata, rsp_rdata, reg_wdata, reg_wdata2, data2;
	hpp_data_t regs [16];
	int error_cnt, checks, wr_cnt, rd_cnt, wr2_cnt, rd2_cnt;

	// {write, mux, addr, data}
	localparam logic [13:0] ROWS [10] = '{{1'h1, 1'h0, 4'h3, 8'h5A}, {1'h1, 1'h1, 4'hC, 8'hA5},
		{1'h0, 1'h0, 4'h3, 8'h5A}, {1'h0, 1'h1, 4'hC, 8'hA5}, {1'h0, 1'h1, 4'h3, 8'h5A},
		{1'h0, 1'h0, 4'hC, 8'hA5}, {1'h1, 1'h0, 4'hF, 8'h00}, {1'h1, 1'h1, 4'h0, 8'hFF},
		{1'h0, 1'h1, 4'hF, 8'h00}, {1'h0, 1'h0, 4'h0, 8'hFF}};
	// {sources, enables, aux pin, aux enable}
	localparam logic [9:0] IRQS [5] = '{{4'h2, 4'h0, 1'h0, 1'h0}, {4'h2, 4'h2, 1'h0, 1'h0},
		{4'h0, 4'hF, 1'h1, 1'h1}, {4'h0, 4'hF, 1'h1, 1'h0}, {4'h8, 4'h8, 1'h1, 1'h1}};

	always #2 clk_sys_in = ~clk_sys_in;

	hpp_port_if port ();
	hpp_port_if port2 ();

	hpp_dev_end u_hpp_dev_end (.clk_sys_in, .nrst_in, .ce_in(ce), .port(port.dev), .aux_interrupt_in(aux_in),
		.reg_rd_out(reg_rd), .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
		.reg_rdata_in(regs[reg_addr]), .irq_src_in(irq_src), .irq_en_in(irq_en), .aux_irq_en_in(aux_en),
		.aux_irq_out(aux_irq), .mux_mode_out(mux_mode));
	hpp_host_end u_hpp_host_end (.clk_sys_in, .nrst_in, .ce_in(ce), .port(port.host), .cmd_valid_in(cmd_valid),
		.cmd_ready_out(cmd_ready), .cmd_write_in(cmd_write), .cmd_mux_in(cmd_mux), .cmd_addr_in(cmd_addr),
		.cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rsp_rdata), .irq_out(irq));
	// second device end: pins driven by hand so faults of the host can be made
	hpp_dev_end u_hpp_dev_end_2 (.clk_sys_in, .nrst_in, .ce_in(ce), .port(port2.dev), .aux_interrupt_in(aux_in),
		.reg_rd_out(reg_rd2), .reg_wr_out(reg_wr2), .reg_addr_out(reg_addr2), .reg_wdata_out(reg_wdata2),
		.reg_rdata_in(8'hC3), .irq_src_in(irq_src), .irq_en_in(irq_en), .aux_irq_en_in(aux_en),
		.aux_irq_out(), .mux_mode_out(mux_mode2));
	hpp_port_checker u_hpp_port_checker (.clk_sys_in, .nrst_in, .ale(port.ale), .cs_n(port.cs_n),
		.rd_n(port.rd_n), .wr_n(port.wr_n), .register_select_lines(port.register_select_lines),
		.dev_data(port.dev_data), .dev_oe(port.dev_oe));

	// ------------------------------------------------------------
	// register file model and pulse counters
	// ------------------------------------------------------------
	always @(posedge clk_sys_in) begin
		if (reg_wr === 1'h1) begin
			regs[reg_addr] <= reg_wdata;
			wr_cnt++;
		end
		if (reg_rd === 1'h1) rd_cnt++;
		if (mux_mode === 1'h1) saw_mux = 1'h1;
		if (reg_wr2 === 1'h1) begin
			wr2_cnt++;
			addr2 = reg_addr2;
			data2 = reg_wdata2;
		end
		if (reg_rd2 === 1'h1) rd2_cnt++;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk8(input hpp_data_t got, input hpp_data_t exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask : chk1

	task report_and_stop;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// one command through the host end; ready is sampled before it moves
	task do_cmd(input logic w, input logic m, input hpp_addr_t a, input hpp_data_t d);
		int n;
		wr_cnt = 0;
		rd_cnt = 0;
		saw_mux = 1'h0;
		cmd_valid <= 1'h1;
		cmd_write <= w;
		cmd_mux <= m;
		cmd_addr <= a;
		cmd_wdata <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (cmd_ready !== 1'h1 && n < 100);
		chk1(cmd_ready, 1'h1);
		cmd_valid <= 1'h0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (rsp_valid !== 1'h1 && n < 300);
		// a response that never comes counts as a mismatch here
		chk1(rsp_valid, 1'h1);
	endtask : do_cmd

	// hand driven pins of the second port, held for n cycles
	task pins2(input logic a, input logic c, input logic rd, input logic wr, input hpp_data_t d, input int n);
		port2.ale <= a;
		port2.cs_n <= c;
		port2.rd_n <= rd;
		port2.wr_n <= wr;
		port2.host_data <= d;
		repeat (n) @(posedge clk_sys_in);
	endtask : pins2

	initial begin
		repeat (5000) @(posedge clk_sys_in);
		error_cnt++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		foreach (regs[i]) regs[i] = 8'hEE;
		{cmd_valid, cmd_write, cmd_mux, aux_in, aux_en} = 5'h00;
		{irq_src, irq_en, cmd_addr, cmd_wdata} = 20'h00000;
		{port2.ale, port2.cs_n, port2.rd_n, port2.wr_n, port2.host_oe} = 5'h0E;
		port2.register_select_lines = 4'h5;
		port2.host_data = 8'h00;
		repeat (12) @(posedge clk_sys_in);
		nrst_in <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		chk1(mux_mode, 1'h0);
		chk1(port.dev_oe, 1'h0);
		chk1(port.int_n, 1'h1);
		for (int i = 0; i < 10; i++) begin
			r = ROWS[i];
			do_cmd(r[13], r[12], r[11:8], r[7:0]);
			repeat (6) @(posedge clk_sys_in);
			chk1(saw_mux, r[12]);
			chk1(mux_mode, 1'h0);
			chk8(8'(wr_cnt), {7'h0, r[13]});
			chk8(8'(rd_cnt), {7'h0, ~r[13]});
			if (r[13]) chk8(regs[r[11:8]], r[7:0]);
			else chk8(rsp_rdata, r[7:0]);
		end
		for (int i = 0; i < 5; i++) begin
			q = IRQS[i];
			irq_src <= q[9:6];
			irq_en <= q[5:2];
			aux_in <= q[1];
			aux_en <= q[0];
			repeat (8) @(posedge clk_sys_in);
			pend = (|(q[9:6] & q[5:2])) | (q[1] & q[0]);
			chk1(port.int_n, ~pend);
			chk1(irq, pend);
			chk1(aux_irq, q[1]);
		end
		// strobes with chip select high are refused in either mode
		port2.host_oe <= 1'h1;
		pins2(1'h0, 1'h1, 1'h0, 1'h0, 8'h77, 10);
		pins2(1'h1, 1'h1, 1'h1, 1'h1, 8'h09, 5);
		pins2(1'h0, 1'h1, 1'h1, 1'h1, 8'h09, 5);
		chk1(mux_mode2, 1'h1);
		pins2(1'h0, 1'h1, 1'h1, 1'h0, 8'h66, 8);
		chk8(8'(wr2_cnt + rd2_cnt), 8'h00);
		pins2(1'h0, 1'h0, 1'h1, 1'h1, 8'h66, 4);
		pins2(1'h0, 1'h0, 1'h1, 1'h0, 8'h66, 8);
		pins2(1'h0, 1'h0, 1'h1, 1'h1, 8'h66, 5);
		chk8(8'(wr2_cnt), 8'h01);
		chk8({4'h0, addr2}, 8'h09);
		chk8(data2, 8'h66);
		pins2(1'h0, 1'h1, 1'h1, 1'h1, 8'h00, 6);
		chk1(mux_mode2, 1'h0);
		pins2(1'h0, 1'h0, 1'h0, 1'h0, 8'h44, 8);
		pins2(1'h0, 1'h1, 1'h1, 1'h1, 8'h44, 6);
		chk8({4'h0, addr2}, 8'h05);
		chk8(data2, 8'h44);
		chk8(8'(wr2_cnt), 8'h02);
		// a latch enable pulse while the clock enable is low leaves no trace
		ce <= 1'h0;
		pins2(1'h1, 1'h1, 1'h1, 1'h1, 8'h00, 6);
		ce <= 1'h1;
		pins2(1'h0, 1'h1, 1'h1, 1'h1, 8'h00, 6);
		chk1(mux_mode2, 1'h0);
		// reset in the middle of a multiplexed read
		cmd_valid <= 1'h1;
		cmd_write <= 1'h0;
		cmd_mux <= 1'h1;
		cmd_addr <= 4'hC;
		@(posedge clk_sys_in);
		cmd_valid <= 1'h0;
		repeat (9) @(posedge clk_sys_in);
		chk1(mux_mode, 1'h1);
		nrst_in <= 1'h0;
		repeat (2) @(posedge clk_sys_in);
		chk1(mux_mode, 1'h0);
		chk1(port.dev_oe, 1'h0);
		nrst_in <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		do_cmd(1'h0, 1'h0, 4'hF, 8'h00);
		chk8(rsp_rdata, 8'h00);
		report_and_stop();
	end

endmodule : host_parallel_bus_port_test

`default_nettype wire
